// ---- rtl/ccd_pkg.sv ----
`default_nettype none
package ccd_pkg;
  // Opcode bytes
  localparam logic [7:0] CCD_ESC       = 8'h0F;
  localparam logic [7:0] CCD_OP_MOVO   = 8'h40;
  localparam logic [7:0] CCD_OP_MOVNO  = 8'h41;
  localparam logic [7:0] CCD_OP_MOVS   = 8'h48;
  localparam logic [7:0] CCD_OP_MOVNS  = 8'h49;
  localparam logic [7:0] CCD_OP_MOVP   = 8'h4A;
  localparam logic [7:0] CCD_OP_SRD    = 8'h3C;
  localparam logic [7:0] CCD_OP_SWR    = 8'h3D;
  localparam logic [7:0] CCD_OP_X8     = 8'hC7;
  localparam logic [6:0] CCD_XCHG_PAT  = 7'h58;   // 1011000w
  localparam logic [5:0] CCD_CMP_PAT   = 6'h0E;   // 001110dw
  localparam logic [5:0] CCD_IMM_PAT   = 6'h20;   // 100000sw
  localparam logic [2:0] CCD_REG_CMP   = 3'h7;
  localparam logic [2:0] CCD_REG_X8    = 3'h1;
  localparam logic [1:0] CCD_MOD_REG   = 2'h3;
  // Clock counts on a cache hit
  localparam logic [3:0] CCD_CLK_ONE   = 4'h1;
  localparam logic [3:0] CCD_CLK_XCHG  = 4'h6;
  localparam logic [3:0] CCD_CLK_NONE  = 4'h0;

  typedef enum logic [3:0] {
    CCD_K_NONE  = 4'h0,
    CCD_K_CMOV  = 4'h1,
    CCD_K_CMPRR = 4'h2,
    CCD_K_CMPRM = 4'h3,
    CCD_K_CMPMR = 4'h4,
    CCD_K_CMPI  = 4'h5,
    CCD_K_XCHG  = 4'h6,
    CCD_K_XCH8  = 4'h7,
    CCD_K_SRD   = 4'h8,
    CCD_K_SWR   = 4'h9
  } ccd_kind_t;

  typedef enum logic [2:0] {
    CCD_C_O  = 3'h0,
    CCD_C_NO = 3'h1,
    CCD_C_S  = 3'h2,
    CCD_C_NS = 3'h3,
    CCD_C_P  = 3'h4
  } ccd_cond_t;

  typedef enum logic [1:0] {
    CCD_IDLE = 2'b00,
    CCD_BUSY = 2'b01
  } ccd_state_t;
endpackage
`default_nettype wire

// ---- rtl/ccd_classify.sv ----
`default_nettype none
module ccd_classify
  import ccd_pkg::*;
(
  input  wire logic       two_byte,
  input  wire logic [7:0] op,
  input  wire logic [7:0] modrm,
  output var  ccd_kind_t  kind,
  output var  ccd_cond_t  cond,
  output var  logic [3:0] clocks,
  output var  logic       wide,
  output var  logic       dir,
  output var  logic       sext,
  output var  logic       flags_wr
);
  logic [1:0] md;
  logic [2:0] rg;
  assign md = modrm[7:6];
  assign rg = modrm[5:3];

  always_comb
  begin
    kind     = CCD_K_NONE;
    cond     = CCD_C_O;
    clocks   = CCD_CLK_NONE;
    wide     = op[0];
    dir      = 1'b0;
    sext     = 1'b0;
    flags_wr = 1'b0;
    if (two_byte)
    begin
      unique case (op)
        CCD_OP_MOVO:
        begin
          kind = CCD_K_CMOV;  // [RULE1]
          cond = CCD_C_O;
        end
        CCD_OP_MOVNO:
        begin
          kind = CCD_K_CMOV;  // [RULE2]
          cond = CCD_C_NO;
        end
        CCD_OP_MOVP:
        begin
          kind = CCD_K_CMOV;  // [RULE3]
          cond = CCD_C_P;
        end
        CCD_OP_MOVS:
        begin
          kind = CCD_K_CMOV;  // [RULE4]
          cond = CCD_C_S;
        end
        CCD_OP_MOVNS:
        begin
          kind = CCD_K_CMOV;  // [RULE4]
          cond = CCD_C_NS;
        end
        CCD_OP_SRD: kind = CCD_K_SRD;  // [RULE10]
        CCD_OP_SWR: kind = CCD_K_SWR;  // [RULE11]
        CCD_OP_X8:
          if (rg == CCD_REG_X8 && md != CCD_MOD_REG)
            kind = CCD_K_XCH8;  // [RULE9]
        default:
          if (op[7:1] == CCD_XCHG_PAT)
          begin
            kind     = CCD_K_XCHG;  // [RULE8]
            flags_wr = 1'b1;
          end
      endcase
      if (kind == CCD_K_CMOV)
        wide = 1'b1;
    end
    else if (op[7:2] == CCD_CMP_PAT)
    begin
      flags_wr = 1'b1;
      dir      = op[1];
      if (md == CCD_MOD_REG)
        kind = CCD_K_CMPRR;  // [RULE5]
      else if (op[1])
        kind = CCD_K_CMPRM;  // [RULE6]
      else
        kind = CCD_K_CMPMR;  // [RULE6]
    end
    else if (op[7:2] == CCD_IMM_PAT && rg == CCD_REG_CMP)
    begin
      kind     = CCD_K_CMPI;  // [RULE7]
      sext     = op[1];
      flags_wr = 1'b1;
    end
    unique case (kind)
      CCD_K_XCHG: clocks = CCD_CLK_XCHG;  // [RULE8]
      CCD_K_XCH8,
      CCD_K_NONE: clocks = CCD_CLK_NONE;  // [RULE9]
      default:    clocks = CCD_CLK_ONE;
    endcase
  end
endmodule
`default_nettype wire

// ---- rtl/ccd_decode.sv ----
// How it works
// RULE1: 0F 40 moves when overflow set; flags kept; one clock.
// RULE2: 0F 41 moves when overflow clear; flags kept; one clock.
// RULE3: 0F 4A moves when parity even; flags kept; one clock.
// RULE4: 0F 48 moves on sign set, 0F 49 on sign clear; one clock.
// RULE5: 001110dw with mod 11 is register compare, writes flags, one clock.
// RULE6: 0011101w/0011100w with memory operand compare in one clock.
// RULE7: 100000sw with reg 111 compares immediate; s sign-extends byte.
// RULE8: 0F 1011000w is compare-and-exchange, writes flags, six clocks.
// RULE9: 0F C7 reg 001 memory operand is eight-byte exchange; no count.
// RULE10: 0F 3C reads special register in one clock.
// RULE11: 0F 3D writes special register in one clock.
// RULE12: False move condition keeps destination; source still read, same time.
`default_nettype none
module ccd_decode
  import ccd_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       in_valid,
  input  wire logic       in_two_byte,
  input  wire logic [7:0] in_op,
  input  wire logic [7:0] in_modrm,
  input  wire logic       flag_of,
  input  wire logic       flag_sf,
  input  wire logic       flag_pf,
  output logic            in_ready,
  output logic            out_valid,
  output logic [3:0]      out_kind,
  output logic [3:0]      out_clocks,
  output logic            out_dest_wr,
  output logic            out_src_rd,
  output logic            out_flags_wr,
  output logic            out_wide,
  output logic            out_dir,
  output logic            out_sext,
  output logic            out_mem,
  output logic            out_done
);
  typedef struct packed {
    ccd_state_t st;
    logic [3:0] left;
    logic       rdy;
    logic       vld;
    logic [3:0] kind;
    logic [3:0] clks;
    logic       dwr;
    logic       srd;
    logic       fwr;
    logic       wide;
    logic       dir;
    logic       sext;
    logic       mem;
    logic       done;
  } ccd_reg_t;

  ccd_reg_t  s_q;
  ccd_reg_t  s_d;
  ccd_kind_t c_kind;
  ccd_cond_t c_cond;
  logic [3:0] c_clk;
  logic       c_wide;
  logic       c_dir;
  logic       c_sext;
  logic       c_fwr;

  ccd_classify u_cls (
    .two_byte (in_two_byte),
    .op       (in_op),
    .modrm    (in_modrm),
    .kind     (c_kind),
    .cond     (c_cond),
    .clocks   (c_clk),
    .wide     (c_wide),
    .dir      (c_dir),
    .sext     (c_sext),
    .flags_wr (c_fwr)
  );

  function automatic logic ccd_cond_true(input ccd_cond_t c,
                                         input logic o,
                                         input logic s,
                                         input logic p);
    unique case (c)
      CCD_C_O:  return o;   // [RULE1]
      CCD_C_NO: return !o;  // [RULE2]
      CCD_C_S:  return s;   // [RULE4]
      CCD_C_NS: return !s;  // [RULE4]
      CCD_C_P:  return p;   // [RULE3]
      default:  return 1'b0;
    endcase
  endfunction

  always_comb
  begin
    s_d      = s_q;
    s_d.vld  = 1'b0;
    s_d.done = 1'b0;
    unique case (s_q.st)
      CCD_IDLE:
        if (in_valid && s_q.rdy)
        begin
          s_d.vld  = 1'b1;
          s_d.kind = c_kind;
          s_d.clks = c_clk;
          s_d.wide = c_wide;
          s_d.dir  = c_dir;
          s_d.sext = c_sext;  // [RULE7]
          s_d.fwr  = c_fwr;   // [RULE5] [RULE8]
          s_d.mem  = in_modrm[7:6] != CCD_MOD_REG;
          s_d.srd  = c_kind != CCD_K_NONE;
          s_d.dwr  = 1'b0;
          if (c_kind == CCD_K_CMOV)
          begin
            s_d.srd = 1'b1;  // [RULE12]
            s_d.dwr = ccd_cond_true(c_cond, flag_of, flag_sf, flag_pf);
          end
          else if (c_kind == CCD_K_SRD || c_kind == CCD_K_XCHG)
            s_d.dwr = 1'b1;  // [RULE10]
          if (c_clk > CCD_CLK_ONE)
          begin
            s_d.st   = CCD_BUSY;  // [RULE8]
            s_d.left = c_clk - CCD_CLK_ONE;
            s_d.rdy  = 1'b0;
          end
          else
            s_d.done = 1'b1;  // [RULE1] [RULE6] [RULE11]
        end
      CCD_BUSY:
      begin
        s_d.left = s_q.left - CCD_CLK_ONE;
        if (s_q.left == CCD_CLK_ONE)
        begin
          s_d.st   = CCD_IDLE;
          s_d.rdy  = 1'b1;
          s_d.done = 1'b1;
        end
      end
      default:
      begin
        s_d.st  = CCD_IDLE;
        s_d.rdy = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q      <= '0;
      s_q.st   <= CCD_IDLE;
      s_q.rdy  <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign in_ready     = s_q.rdy;
  assign out_valid    = s_q.vld;
  assign out_kind     = s_q.kind;
  assign out_clocks   = s_q.clks;
  assign out_dest_wr  = s_q.dwr;
  assign out_src_rd   = s_q.srd;
  assign out_flags_wr = s_q.fwr;
  assign out_wide     = s_q.wide;
  assign out_dir      = s_q.dir;
  assign out_sext     = s_q.sext;
  assign out_mem      = s_q.mem;
  assign out_done     = s_q.done;
endmodule
`default_nettype wire

// ---- testbench/ccd_decode_checker.sv ----
`default_nettype none
module ccd_decode_checker (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       in_valid,
  input wire logic       in_two_byte,
  input wire logic [7:0] in_op,
  input wire logic [7:0] in_modrm,
  input wire logic       flag_of,
  input wire logic       in_ready,
  input wire logic       out_valid,
  input wire logic [3:0] out_kind,
  input wire logic [3:0] out_clocks,
  input wire logic       out_dest_wr,
  input wire logic       out_src_rd,
  input wire logic       out_flags_wr,
  input wire logic       out_sext,
  input wire logic       out_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic       tk;
  logic       tw;
  assign tk = in_valid && in_ready;
  assign tw = tk && in_two_byte;
  a_take_answer: assert property (tk |=> out_valid)
    else $error("no answer after take");
  a_ovf_move: assert property (tw && in_op == 8'h40 |=>
    out_dest_wr == $past(flag_of) && out_src_rd && !out_flags_wr)
    else $error("overflow move wrong");
  a_novf_move: assert property (tw && in_op == 8'h41 |=>
    out_dest_wr == !$past(flag_of) && out_clocks == 4'h1 && out_done)
    else $error("no overflow move wrong");
  a_cmp_reg: assert property (tk && !in_two_byte
    && in_op[7:2] == 6'h0E && in_modrm[7:6] == 2'h3
    |=> out_kind == 4'h2 && out_flags_wr)
    else $error("reg compare wrong");
  a_cmp_mem: assert property (tk && !in_two_byte
    && in_op[7:2] == 6'h0E && in_modrm[7:6] != 2'h3 |=>
    out_kind == ($past(in_op[1]) ? 4'h3 : 4'h4) && out_clocks == 4'h1)
    else $error("memory compare wrong");
  a_cmp_imm: assert property (tk && !in_two_byte
    && in_op[7:2] == 6'h20 && in_modrm[5:3] == 3'h7
    |=> out_kind == 4'h5 && out_sext == $past(in_op[1]))
    else $error("immediate compare wrong");
  a_xchg_busy: assert property (tw && in_op[7:1] == 7'h58 |=>
    (!in_ready && out_kind == 4'h6)[*5] ##1 (in_ready && out_done))
    else $error("exchange timing wrong");
  a_wide_kind: assert property (tw && in_op == 8'hC7 &&
    in_modrm[5:3] == 3'h1 && in_modrm[7:6] != 2'h3 |=> out_kind == 4'h7)
    else $error("eight byte exchange wrong");
  a_special_rw: assert property (tw && in_op[7:1] == 7'h1E |=>
    out_kind == ($past(in_op[0]) ? 4'h9 : 4'h8) && out_clocks == 4'h1)
    else $error("special register access wrong");
endmodule
bind ccd_decode ccd_decode_checker i_ccd_decode_checker (.sys_clk, .rst,
  .in_valid, .in_two_byte, .in_op, .in_modrm, .flag_of, .in_ready,
  .out_valid, .out_kind, .out_clocks, .out_dest_wr, .out_src_rd,
  .out_flags_wr, .out_sext, .out_done);
`default_nettype wire

// ---- testbench/ccd_decode_tb.sv ----
`default_nettype none
module ccd_decode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic       tb;
    logic [7:0] op;
    logic [7:0] mr;
    logic [2:0] f;
    logic [3:0] k;
    logic [3:0] c;
    logic       d;
  } ccd_row_t;
  // Flags field is overflow, sign, parity; d of X is not compared
  ccd_row_t rows [19] = '{
    '{1'h1, 8'h40, 8'hC0, 3'h4, 4'h1, 4'h1, 1'h1},
    '{1'h1, 8'h40, 8'hC0, 3'h3, 4'h1, 4'h1, 1'h0},
    '{1'h1, 8'h41, 8'h06, 3'h0, 4'h1, 4'h1, 1'h1},
    '{1'h1, 8'h41, 8'hC0, 3'h4, 4'h1, 4'h1, 1'h0},
    '{1'h1, 8'h4A, 8'hC0, 3'h1, 4'h1, 4'h1, 1'h1},
    '{1'h1, 8'h4A, 8'hC0, 3'h6, 4'h1, 4'h1, 1'h0},
    '{1'h1, 8'h48, 8'hC0, 3'h2, 4'h1, 4'h1, 1'h1},
    '{1'h1, 8'h48, 8'hC0, 3'h5, 4'h1, 4'h1, 1'h0},
    '{1'h1, 8'h49, 8'hC0, 3'h0, 4'h1, 4'h1, 1'h1},
    '{1'h1, 8'h49, 8'hC0, 3'h2, 4'h1, 4'h1, 1'h0},
    '{1'h0, 8'h39, 8'hC8, 3'h7, 4'h2, 4'h1, 1'h0},
    '{1'h0, 8'h3B, 8'h06, 3'h0, 4'h3, 4'h1, 1'h0},
    '{1'h0, 8'h38, 8'h46, 3'h0, 4'h4, 4'h1, 1'h0},
    '{1'h0, 8'h83, 8'hF8, 3'h0, 4'h5, 4'h1, 1'h0},
    '{1'h1, 8'h3C, 8'h00, 3'h0, 4'h8, 4'h1, 1'h1},
    '{1'h1, 8'h3D, 8'h00, 3'h0, 4'h9, 4'h1, 1'h0},
    '{1'h1, 8'hC7, 8'h0E, 3'h0, 4'h7, 4'h0, 1'hX},
    '{1'h1, 8'hC7, 8'hCE, 3'h0, 4'h0, 4'h0, 1'hX},
    '{1'h0, 8'h90, 8'h00, 3'h0, 4'h0, 4'h0, 1'hX}};
  logic       sys_clk, rst, in_valid, in_two_byte, flag_of, flag_sf, flag_pf;
  logic [7:0] in_op, in_modrm;
  logic       in_ready, out_valid, out_dest_wr, out_src_rd, out_flags_wr;
  logic       out_wide, out_dir, out_sext, out_mem, out_done;
  logic [3:0] out_kind, out_clocks;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         cyc = 0;
  ccd_decode i_ccd_decode (.sys_clk, .rst, .in_valid, .in_two_byte, .in_op,
    .in_modrm, .flag_of, .flag_sf, .flag_pf, .in_ready, .out_valid,
    .out_kind, .out_clocks, .out_dest_wr, .out_src_rd, .out_flags_wr,
    .out_wide, .out_dir, .out_sext, .out_mem, .out_done);
  task automatic chk(input string nm, input logic [3:0] e,
                     input logic [3:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic put(input ccd_row_t r);
    in_valid = 1'h1;
    in_two_byte = r.tb;
    in_op = r.op;
    in_modrm = r.mr;
    {flag_of, flag_sf, flag_pf} = r.f;
  endtask
  initial
  begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial
  begin
    rst = 1'h1;
    in_valid = 1'h0;
    in_two_byte = 1'h0;
    in_op = 8'h00;
    in_modrm = 8'h00;
    {flag_of, flag_sf, flag_pf} = 3'h0;
    repeat (8) @(negedge sys_clk);
    chk("ready_rst", 4'h1, {3'h0, in_ready});
    chk("valid_rst", 4'h0, {3'h0, out_valid});
    chk("kind_rst", 4'h0, out_kind);
    rst = 1'h0;
    put(rows[0]);
    for (int i = 0; i < 19; i++)
    begin
      @(negedge sys_clk);
      chk("valid", 4'h1, {3'h0, out_valid});
      chk("done", 4'h1, {3'h0, out_done});
      chk("kind", rows[i].k, out_kind);
      chk("clocks", rows[i].c, out_clocks);
      chk("flags", {3'h0, rows[i].k inside {[2:5]}},
          {3'h0, out_flags_wr});
      if (rows[i].d !== 1'hX)
        chk("dest", {3'h0, rows[i].d}, {3'h0, out_dest_wr});
      if (rows[i].k == 4'h1)
        chk("src", 4'h1, {3'h0, out_src_rd});
      chk("mem", {3'h0, rows[i].mr[7:6] != 2'h3}, {3'h0, out_mem});
      chk("wide", {3'h0, (rows[i].k == 4'h1) || rows[i].op[0]},
          {3'h0, out_wide});
      chk("dir", {3'h0, rows[i].op[1] && rows[i].k inside {[2:4]}},
          {3'h0, out_dir});
      chk("sext", {3'h0, (rows[i].k == 4'h5) && rows[i].op[1]},
          {3'h0, out_sext});
      if (i < 18)
        put(rows[i + 1]);
    end
    put('{1'h1, 8'hB1, 8'hC8, 3'h0, 4'h6, 4'h6, 1'h1});
    @(negedge sys_clk);
    chk("xchg_kind", 4'h6, out_kind);
    chk("xchg_clocks", 4'h6, out_clocks);
    chk("xchg_flags", 4'h1, {3'h0, out_flags_wr});
    put('{1'h1, 8'hB0, 8'h06, 3'h0, 4'h6, 4'h6, 1'h1});
    repeat (4)
    begin
      @(negedge sys_clk);
      chk("busy_ready", 4'h0, {3'h0, in_ready});
      chk("busy_valid", 4'h0, {3'h0, out_valid});
      chk("busy_kind", 4'h6, out_kind);
    end
    @(negedge sys_clk);
    chk("xchg_done", 4'h1, {3'h0, out_done});
    put(rows[0]);
    @(negedge sys_clk);
    chk("after_busy", 4'h1, out_kind);
    in_valid = 1'h0;
    @(negedge sys_clk);
    rst = 1'h1;
    @(negedge sys_clk);
    chk("ready_rst2", 4'h1, {3'h0, in_ready});
    chk("kind_rst2", 4'h0, out_kind);
    rst = 1'h0;
    put(rows[4]);
    @(negedge sys_clk);
    chk("kind_after_rst", 4'h1, out_kind);
    chk("dest_after_rst", 4'h1, {3'h0, out_dest_wr});
    in_valid = 1'h0;
    @(negedge sys_clk);
    wrap_up();
  end
endmodule
`default_nettype wire
